/* mcu_config_upper.sv */
`timescale 1ns/10ps
module mcu_config_upper
(
    input  wire logic                     ref_clk,      // 100 MHz clock
    input  wire logic                     srst,         // Sync reset
    input  wire logic [mcu_pkg::ADDR_W-1:0] addr,       // Lane address
    input  wire logic [mcu_pkg::DATA_W-1:0] wr_data,    // Write data
    input  wire logic                     wr_stb,       // Write strobe
    input  wire logic                     rd_stb,       // Read strobe
    output logic      [mcu_pkg::DATA_W-1:0] rd_data,    // Read data
    output logic      [4:0]               green_lowgray_comp_level, // 1-16
    output logic      [4:0]               blue_lowgray_comp_level,  // 1-16
    output logic                          red_group_immunity_sel,   // 1 low
    output logic                          green_group_immunity_sel, // 1 low
    output logic                          blue_group_immunity_sel,  // 1 low
    output logic                          subperiod_limit_enable,   // Limit on
    output logic      [8:0]               subperiod_max,  // 0 = no limit
    output logic      [2:0]               module_geometry_sel,      // Code
    output logic      [6:0]               pixel_cols,     // Pixel width
    output logic      [6:0]               pixel_rows,     // Pixel height
    output logic      [2:0]               scan_length,    // Devices scanned
    output logic                          third_stacked_device_rev, // Rev
    output logic                          fourth_stacked_device_rev, // Rev
    output logic      [7:0]               scan_order,     // Slot list
    output logic                          matrix_power_save_enable  // Save
);

    // Compensation code to level
    function automatic logic [4:0] comp_level(input logic [3:0] code);
        comp_level = {1'b0, code} + 5'h01;
    endfunction

    // Geometry decode: cols, rows, length, rev3, rev4, order
    function automatic logic [26:0] geom_info(input logic [2:0] code);
        logic [26:0] r;
        r = '0;
        unique case (code)
            mcu_pkg::GEOM_16X16:
                r = {mcu_pkg::PIX_16, mcu_pkg::PIX_16, 3'h1, 1'b0, 1'b0,
                     mcu_pkg::ORDER_1};
            mcu_pkg::GEOM_32X32:
                r = {mcu_pkg::PIX_32, mcu_pkg::PIX_32, 3'h2, 1'b0, 1'b0,
                     mcu_pkg::ORDER_12};
            mcu_pkg::GEOM_48_SEQA:
                r = {mcu_pkg::PIX_48, mcu_pkg::PIX_48, 3'h3, 1'b1, 1'b0,
                     mcu_pkg::ORDER_123};
            mcu_pkg::GEOM_48_SEQB:
                r = {mcu_pkg::PIX_48, mcu_pkg::PIX_48, 3'h3, 1'b1, 1'b0,
                     mcu_pkg::ORDER_132};
            mcu_pkg::GEOM_4864_A:
                r = {mcu_pkg::PIX_48, mcu_pkg::PIX_64, 3'h3, 1'b1, 1'b1,
                     mcu_pkg::ORDER_123};
            mcu_pkg::GEOM_4864_B:
                r = {mcu_pkg::PIX_48, mcu_pkg::PIX_64, 3'h3, 1'b1, 1'b1,
                     mcu_pkg::ORDER_132};
            mcu_pkg::GEOM_64_SEQA:
                r = {mcu_pkg::PIX_64, mcu_pkg::PIX_64, 3'h4, 1'b1, 1'b1,
                     mcu_pkg::ORDER_1234};
            mcu_pkg::GEOM_64_SEQB:
                r = {mcu_pkg::PIX_64, mcu_pkg::PIX_64, 3'h4, 1'b1, 1'b1,
                     mcu_pkg::ORDER_1423};
        endcase
        geom_info = r;
    endfunction

    logic [mcu_pkg::WORD_W-1:0] cfg_word;
    logic [mcu_pkg::WORD_W-1:0] next_cfg_word;
    logic [mcu_pkg::WORD_W-1:0] lane_mask;
    logic [mcu_pkg::WORD_W-1:0] lane_data;
    logic [mcu_pkg::DATA_W-1:0] next_rd_data;
    logic [mcu_pkg::DATA_W-1:0] lane_read;
    logic [3:0]                 cfg_green;
    logic [3:0]                 cfg_blue;
    logic [2:0]                 cfg_geom;
    logic [26:0]                geom_now;
    logic                       wr_low;
    logic                       wr_mid;
    logic                       wr_high;

    // Lane decode of a write
    assign wr_low  = wr_stb && (addr == mcu_pkg::ADDR_LANE_LOW);
    assign wr_mid  = wr_stb && (addr == mcu_pkg::ADDR_LANE_MID);
    assign wr_high = wr_stb && (addr == mcu_pkg::ADDR_LANE_HIGH);

    // Lane mask and replicated data for a write
    assign lane_mask = wr_low  ? 48'h0000_0000_ffff :
                       wr_mid  ? 48'h0000_ffff_0000 :
                       wr_high ? 48'hffff_0000_0000 : 48'h0;
    assign lane_data = {wr_data, wr_data, wr_data};

    // Only held bits take writes; reserved bits stay zero
    assign next_cfg_word = (cfg_word & ~lane_mask)
                         | (lane_data & lane_mask
                            & mcu_pkg::WRITABLE_MASK);

    // Read lane select; unmapped lane reads zero
    assign lane_read =
        (addr == mcu_pkg::ADDR_LANE_LOW)  ? cfg_word[15:0]  :
        (addr == mcu_pkg::ADDR_LANE_MID)  ? cfg_word[31:16] :
        (addr == mcu_pkg::ADDR_LANE_HIGH) ? cfg_word[47:32] : 16'h0;
    assign next_rd_data = rd_stb ? lane_read : 16'h0;

    // Field views of the stored word
    assign cfg_green = cfg_word[mcu_pkg::GREEN_COMP_LSB +: 4];
    assign cfg_blue  = cfg_word[mcu_pkg::BLUE_COMP_LSB +: 4];
    assign cfg_geom  = cfg_word[mcu_pkg::GEOM_LSB +: 3];
    assign geom_now  = geom_info(cfg_geom);

    // Configuration word and read data
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cfg_word <= mcu_pkg::WORD_RESET;
            rd_data  <= 16'h0;
        end
        else
        begin
            cfg_word <= next_cfg_word;
            rd_data  <= next_rd_data;
        end
    end

    // Compensation levels and channel immunity
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            green_lowgray_comp_level <= 5'h01;
            blue_lowgray_comp_level  <= 5'h01;
            red_group_immunity_sel   <= 1'b1;
            green_group_immunity_sel <= 1'b1;
            blue_group_immunity_sel  <= 1'b1;
        end
        else
        begin
            green_lowgray_comp_level <= comp_level(cfg_green);
            blue_lowgray_comp_level  <= comp_level(cfg_blue);
            red_group_immunity_sel   <=
                cfg_word[mcu_pkg::RED_IMM_BIT];
            green_group_immunity_sel <=
                cfg_word[mcu_pkg::GREEN_IMM_BIT];
            blue_group_immunity_sel  <=
                cfg_word[mcu_pkg::BLUE_IMM_BIT];
        end
    end

    // Subperiod limit and power saving
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            subperiod_limit_enable   <= 1'b0;
            subperiod_max            <= 9'h000;
            matrix_power_save_enable <= 1'b0;
        end
        else
        begin
            subperiod_limit_enable   <= cfg_word[mcu_pkg::SUBP_LIM_BIT];
            subperiod_max            <= cfg_word[mcu_pkg::SUBP_LIM_BIT]
                                      ? mcu_pkg::SUBPERIOD_LIMIT
                                      : 9'h000;
            matrix_power_save_enable <= cfg_word[mcu_pkg::PSAVE_BIT];
        end
    end

    // Geometry outputs follow the stored code
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            module_geometry_sel       <= mcu_pkg::GEOM_64_SEQB;
            pixel_cols                <= mcu_pkg::PIX_64;
            pixel_rows                <= mcu_pkg::PIX_64;
            scan_length               <= 3'h4;
            third_stacked_device_rev  <= 1'b1;
            fourth_stacked_device_rev <= 1'b1;
            scan_order                <= mcu_pkg::ORDER_1423;
        end
        else
        begin
            module_geometry_sel       <= cfg_geom;
            {pixel_cols, pixel_rows, scan_length,
             third_stacked_device_rev, fourth_stacked_device_rev,
             scan_order}              <= geom_now;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // Write to one lane, then no further write to it
    sequence s_mid_write;
        wr_mid ##1 !wr_mid;
    endsequence

    sequence s_high_write;
        wr_high ##1 !wr_high;
    endsequence

    // High lane write, then a read of that lane in the next cycle
    sequence s_high_write_read;
        wr_high ##1 (rd_stb && addr == 2'h2);
    endsequence

    a_green_level_map: assert property
        (s_mid_write |=> green_lowgray_comp_level
            == {1'b0, $past(wr_data[15:12], 2)} + 5'h01)
        else $error("green compensation level wrong");

    a_blue_level_map: assert property
        (s_high_write |=> blue_lowgray_comp_level
            == {1'b0, $past(wr_data[3:0], 2)} + 5'h01)
        else $error("blue compensation level wrong");

    a_red_imm_write: assert property
        (s_high_write |=> red_group_immunity_sel
            == $past(wr_data[7], 2))
        else $error("red immunity select wrong");

    a_green_imm_write: assert property
        (s_high_write |=> green_group_immunity_sel
            == $past(wr_data[8], 2))
        else $error("green immunity select wrong");

    a_blue_imm_write: assert property
        (s_high_write |=> blue_group_immunity_sel
            == $past(wr_data[9], 2))
        else $error("blue immunity select wrong");

    a_subp_limit_value: assert property
        (s_high_write |=> subperiod_limit_enable
            == $past(wr_data[10], 2)
         && subperiod_max == ($past(wr_data[10], 2) ? 9'h100 : 9'h000))
        else $error("subperiod limit wrong");

    a_geom_small_sizes: assert property
        (!srst && cfg_geom == 3'h1 |=> pixel_cols == 7'h20
            && pixel_rows == 7'h20 && scan_length == 3'h2
            && !third_stacked_device_rev && scan_order == 8'h04)
        else $error("32x32 geometry decode wrong");

    a_geom_single_dev: assert property
        (!srst && cfg_geom == 3'h0 |=> pixel_cols == 7'h10
            && scan_length == 3'h1 && !fourth_stacked_device_rev)
        else $error("16x16 geometry decode wrong");

    a_geom_48_three: assert property
        (!srst && cfg_geom == 3'h3 |=> pixel_rows == 7'h30
            && third_stacked_device_rev && !fourth_stacked_device_rev
            && scan_order == 8'h18)
        else $error("48x48 geometry decode wrong");

    a_geom_4864_rev: assert property
        (!srst && cfg_geom == 3'h4 |=> pixel_cols == 7'h30
            && pixel_rows == 7'h40 && third_stacked_device_rev
            && fourth_stacked_device_rev && scan_order == 8'h24)
        else $error("48x64 geometry decode wrong");

    a_geom_64_order: assert property
        (!srst && cfg_geom == 3'h7 |=> pixel_cols == 7'h40
            && scan_length == 3'h4 && scan_order == 8'h9c
            && fourth_stacked_device_rev)
        else $error("64x64 geometry decode wrong");

    a_psave_follow: assert property
        (s_high_write |=> matrix_power_save_enable
            == $past(wr_data[15], 2))
        else $error("power save enable wrong");

    a_resv_read_zero: assert property
        (rd_stb && addr == 2'h2 |=> rd_data[6:4] == 3'h0
            && !rd_data[14])
        else $error("reserved bits read nonzero");

    a_low_lane_zero: assert property
        (rd_stb && addr != 2'h2 |=> rd_data[11:0] == 12'h000)
        else $error("unheld bits read nonzero");

    a_read_only_after: assert property
        (!rd_stb |=> rd_data == 16'h0)
        else $error("read data outside read cycle");

    a_reset_geometry: assert property
        (@(posedge ref_clk) disable iff (1'b0)
         srst |=> module_geometry_sel == 3'h7
            && red_group_immunity_sel && !matrix_power_save_enable
            && green_lowgray_comp_level == 5'h01)
        else $error("reset values wrong");

    a_geom_48_seqa: assert property
        (!srst && cfg_geom == 3'h2 |=> pixel_cols == 7'h30
            && pixel_rows == 7'h30 && scan_length == 3'h3
            && third_stacked_device_rev && !fourth_stacked_device_rev
            && scan_order == 8'h24)
        else $error("48x48 first order decode wrong");

    a_geom_4864_seqb: assert property
        (!srst && cfg_geom == 3'h5 |=> pixel_cols == 7'h30
            && pixel_rows == 7'h40 && scan_length == 3'h3
            && third_stacked_device_rev && fourth_stacked_device_rev
            && scan_order == 8'h18)
        else $error("48x64 second order decode wrong");

    a_geom_64_seqa: assert property
        (!srst && cfg_geom == 3'h6 |=> pixel_cols == 7'h40
            && pixel_rows == 7'h40 && scan_length == 3'h4
            && third_stacked_device_rev && fourth_stacked_device_rev
            && scan_order == 8'he4)
        else $error("64x64 first order decode wrong");

    a_geom_code_write: assert property
        (s_high_write |=> module_geometry_sel
            == $past(wr_data[13:11], 2))
        else $error("geometry code not taken from write");

    a_green_lane_keep: assert property
        (s_high_write |=> $stable(green_lowgray_comp_level))
        else $error("high lane write moved green level");

    a_write_read_back: assert property
        (s_high_write_read |=> rd_data
            == ($past(wr_data, 2) & 16'hbf8f))
        else $error("written lane reads back wrong");

    a_zero_lane_read: assert property
        (rd_stb && (addr == 2'h0 || addr == 2'h3)
            |=> rd_data == 16'h0000)
        else $error("unheld lane reads nonzero");

    a_level_range: assert property
        (green_lowgray_comp_level != 5'h00
            && green_lowgray_comp_level <= 5'h10
            && blue_lowgray_comp_level != 5'h00
            && blue_lowgray_comp_level <= 5'h10)
        else $error("compensation level out of range");

    a_subp_max_pair: assert property
        (subperiod_max == (subperiod_limit_enable ? 9'h100 : 9'h000))
        else $error("subperiod ceiling and enable disagree");

    a_reset_fields: assert property
        (@(posedge ref_clk) disable iff (1'b0)
         srst |=> blue_lowgray_comp_level == 5'h01
            && green_group_immunity_sel && blue_group_immunity_sel
            && !subperiod_limit_enable && subperiod_max == 9'h000
            && scan_order == 8'h9c && rd_data == 16'h0000)
        else $error("reset values of fields wrong");

endmodule // mcu_config_upper

/* mcu_pkg.sv */
// Function
// - Green/blue low-gray compensation, levels 1 to 16
// - Red group immunity select, resets low immunity
// - Green group immunity select, resets low immunity
// - Blue group immunity select, resets low immunity
// - Bit 42 limits maximum subperiod to 256
// - Geometry codes 000b, 001b: 16x16, 32x32
// - Codes 010b/011b: 48x48, third device reversed
// - Codes 100b/101b: 48x64, third, fourth reversed
// - Codes 110b/111b: 64x64, third, fourth reversed
// - Bit 47 enables matrix power saving
package mcu_pkg;

    // Register port shape
    localparam int DATA_W = 16;
    localparam int ADDR_W = 2;
    localparam int WORD_W = 48;

    // Word lanes of the 48-bit word, 16 bits each
    localparam logic [ADDR_W-1:0] ADDR_LANE_LOW  = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_LANE_MID  = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_LANE_HIGH = 2'h2;

    // Field positions inside the 48-bit word
    localparam int GREEN_COMP_LSB = 28;
    localparam int BLUE_COMP_LSB  = 32;
    localparam int RED_IMM_BIT    = 39;
    localparam int GREEN_IMM_BIT  = 40;
    localparam int BLUE_IMM_BIT   = 41;
    localparam int SUBP_LIM_BIT   = 42;
    localparam int GEOM_LSB       = 43;
    localparam int PSAVE_BIT      = 47;

    // Bits held by this block, and reset word
    localparam logic [WORD_W-1:0] WRITABLE_MASK = 48'hbf8f_f000_0000;
    localparam logic [WORD_W-1:0] WORD_RESET    = 48'h3b80_0000_0000;

    // Subperiod ceiling when the limit is on
    localparam logic [8:0] SUBPERIOD_LIMIT = 9'h100;

    // Geometry select codes
    localparam logic [2:0] GEOM_16X16    = 3'h0;
    localparam logic [2:0] GEOM_32X32    = 3'h1;
    localparam logic [2:0] GEOM_48_SEQA  = 3'h2;
    localparam logic [2:0] GEOM_48_SEQB  = 3'h3;
    localparam logic [2:0] GEOM_4864_A   = 3'h4;
    localparam logic [2:0] GEOM_4864_B   = 3'h5;
    localparam logic [2:0] GEOM_64_SEQA  = 3'h6;
    localparam logic [2:0] GEOM_64_SEQB  = 3'h7;

    // Pixel sizes
    localparam logic [6:0] PIX_16 = 7'h10;
    localparam logic [6:0] PIX_32 = 7'h20;
    localparam logic [6:0] PIX_48 = 7'h30;
    localparam logic [6:0] PIX_64 = 7'h40;

    // Scan orders: slot i in bits 2i+1:2i, device index from zero
    localparam logic [7:0] ORDER_1    = 8'h00;
    localparam logic [7:0] ORDER_12   = 8'h04;
    localparam logic [7:0] ORDER_123  = 8'h24;
    localparam logic [7:0] ORDER_132  = 8'h18;
    localparam logic [7:0] ORDER_1234 = 8'he4;
    localparam logic [7:0] ORDER_1423 = 8'h9c;

endpackage

/* tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    // One row: lane inputs, geometry expected for the row index as code
    typedef struct packed {
        logic [15:0] d1;   // Lane one data
        logic [15:0] d2;   // Lane two data
        logic [6:0]  cols; // Expected width
        logic [6:0]  rows; // Expected height
        logic [2:0]  len;  // Expected scan length
        logic        r3;   // Third device reversed
        logic        r4;   // Fourth device reversed
        logic [7:0]  ord;  // Expected slot list
    } mcu_row_s;

    localparam logic [15:0] MASK1 = 16'hf000;
    localparam logic [15:0] MASK2 = 16'hbf8f;

    logic                        ref_clk = 1'b0;
    logic                        srst    = 1'b1;
    logic [mcu_pkg::ADDR_W-1:0]  addr    = '0;
    logic [mcu_pkg::DATA_W-1:0]  wr_data = '0;
    logic                        wr_stb  = 1'b0;
    logic                        rd_stb  = 1'b0;
    logic [mcu_pkg::DATA_W-1:0]  rd_data;
    logic [4:0]                  green_lvl;
    logic [4:0]                  blue_lvl;
    logic                        red_imm, green_imm, blue_imm;
    logic                        subp_en;
    logic [8:0]                  subp_max;
    logic [2:0]                  geom;
    logic [6:0]                  cols, rows;
    logic [2:0]                  scan_len;
    logic                        rev3, rev4;
    logic [7:0]                  order;
    logic                        psave;
    int                          bad_count = 0;
    int                          compares  = 0;
    int                          cycles    = 0;
    mcu_row_s                    tbl [8];

    // Clock at 100 MHz
    always #5 ref_clk = ~ref_clk;

    mcu_config_upper mcu_config_upper_inst (
        .ref_clk(ref_clk), .srst(srst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .green_lowgray_comp_level(green_lvl),
        .blue_lowgray_comp_level(blue_lvl),
        .red_group_immunity_sel(red_imm),
        .green_group_immunity_sel(green_imm),
        .blue_group_immunity_sel(blue_imm),
        .subperiod_limit_enable(subp_en), .subperiod_max(subp_max),
        .module_geometry_sel(geom), .pixel_cols(cols), .pixel_rows(rows),
        .scan_length(scan_len), .third_stacked_device_rev(rev3),
        .fourth_stacked_device_rev(rev4), .scan_order(order),
        .matrix_power_save_enable(psave)
    );

    // Prints the counts and the verdict, then stops
    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Cuts a hang short
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One write cycle; strobe drops at the next edge
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge ref_clk);
        wr_stb  <= 1'b0;
    endtask

    // One read cycle; data looked at in the cycle after the strobe
    task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask

    // Compares every decoded output with what the lane data imply
    task automatic check_out(input logic [15:0] d1, input logic [15:0] d2);
        mcu_row_s g;
        g = tbl[d2[13:11]];
        chk(green_lvl, {1'b0, d1[15:12]} + 5'h01);
        chk(blue_lvl, {1'b0, d2[3:0]} + 5'h01);
        chk(red_imm, d2[7]);
        chk(green_imm, d2[8]);
        chk(blue_imm, d2[9]);
        chk(subp_en, d2[10]);
        chk(subp_max, d2[10] ? 9'h100 : 9'h000);
        chk(geom, d2[13:11]);
        chk({cols, rows}, {g.cols, g.rows});
        chk({scan_len, rev3, rev4}, {g.len, g.r3, g.r4});
        chk(order, g.ord);
        chk(psave, d2[15]);
    endtask

    initial
    begin
        tbl[0] = {16'h0abc, 16'hc570, 7'h10, 7'h10, 3'h1, 2'b00, 8'h00};
        tbl[1] = {16'hf123, 16'h0a8f, 7'h20, 7'h20, 3'h2, 2'b00, 8'h04};
        tbl[2] = {16'h7fff, 16'h1387, 7'h30, 7'h30, 3'h3, 2'b10, 8'h24};
        tbl[3] = {16'h3000, 16'h9c05, 7'h30, 7'h30, 3'h3, 2'b10, 8'h18};
        tbl[4] = {16'h9555, 16'h220a, 7'h30, 7'h40, 3'h3, 2'b11, 8'h24};
        tbl[5] = {16'h1000, 16'h6903, 7'h30, 7'h40, 3'h3, 2'b11, 8'h18};
        tbl[6] = {16'he000, 16'h308c, 7'h40, 7'h40, 3'h4, 2'b11, 8'he4};
        tbl[7] = {16'h5000, 16'hbffe, 7'h40, 7'h40, 3'h4, 2'b11, 8'h9c};
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        // Reset values of outputs and lanes
        chk(rd_data, 16'h0000);
        check_out(16'h0000, 16'h3b80);
        rd_chk(2'h2, 16'h3b80);
        rd_chk(2'h1, 16'h0000);
        $display("test reset done");
        // Geometry codes 0 to 7 (row i writes code i), some reserved bits written as ones
        for (int i = 0; i < 8; i++)
        begin
            wr(2'h1, tbl[i].d1);
            wr(2'h2, tbl[i].d2);
            repeat (2) @(posedge ref_clk);
            #1;
            check_out(tbl[i].d1, tbl[i].d2);
            rd_chk(2'h1, tbl[i].d1 & MASK1);
            rd_chk(2'h2, tbl[i].d2 & MASK2);
        end
        $display("test table done");
        // Unmapped and foreign lanes ignore writes and read zero
        wr(2'h0, 16'hffff);
        wr(2'h3, 16'hffff);
        rd_chk(2'h0, 16'h0000);
        rd_chk(2'h3, 16'h0000);
        rd_chk(2'h2, tbl[7].d2 & MASK2);
        $display("test unmapped done");
        // Write then read with no gap; data stands one cycle only
        @(posedge ref_clk);
        addr    <= 2'h2;
        wr_data <= 16'h4a55;
        wr_stb  <= 1'b1;
        @(posedge ref_clk);
        wr_stb  <= 1'b0;
        rd_stb  <= 1'b1;
        @(posedge ref_clk);
        rd_stb  <= 1'b0;
        #1;
        chk(rd_data, 16'h0a05);
        @(posedge ref_clk);
        #1;
        chk(rd_data, 16'h0000);
        check_out(tbl[7].d1, 16'h4a55);
        $display("test back to back done");
        // Reset in mid-run restores every field
        @(posedge ref_clk);
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check_out(16'h0000, 16'h3b80);
        rd_chk(2'h2, 16'h3b80);
        rd_chk(2'h1, 16'h0000);
        $display("test second reset done");
        end_sim();
    end
endmodule // tb_top
